// >>> design/lcdcdc_core.sv
`include "lcdcdc_regs.svh"
// Command interpreter and display control
module lcdcdc_core #(
  parameter int RESET_CYC = `LCDCDC_RESET_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // Strap and status
  input  wire logic [1:0]  i_host_bus_select,
  output logic      [1:0]  o_host_bus_mode,
  output logic             o_reset_pending_flag,
  output logic             o_driver_enable_flag,
  // Driver controls
  output lcdcdc_pkg::lcdcdc_drv_s o_drv,
  output logic             o_row_hiz,
  output logic             o_col_gnd,
  output logic      [6:0]  o_column_pointer,
  output logic      [4:0]  o_page_pointer,
  output logic             o_line_tick,
  output logic             o_frame_tick
);
  // =====================================================================
  // State
  logic [6:0]  column_pointer_ff;
  logic [6:0]  cursor_save_reg_ff;
  logic [4:0]  page_pointer_ff;
  logic [6:0]  max_col_ff;
  logic [3:0]  ram_addr_ctrl_ff;   // [3]=cursor [2]=dir [1]=order [0]=wrap
  logic [2:0]  display_ctrl_bits_ff;
  logic        all_on_flag_ff;
  logic        invert_flag_ff;
  logic [6:0]  lcd_ctrl_bits_ff;
  logic [1:0]  bias_select_ff;
  logic [1:0]  temp_coef_select_ff;
  logic [3:0]  pump_ctrl_bits_ff;
  logic [1:0]  mux_ratio_select_ff;
  logic [3:0]  fixed_row_band_ff;
  logic [6:0]  scroll_offset_ff;
  logic [1:0]  gain_select_ff;
  logic [5:0]  pot_value_ff;
  logic [1:0]  second_ff;          // 1 maxcol, 2 gain, 3 swallow
  logic [22:0] rst_cnt_ff;
  logic        rst_busy_ff;
  logic        strap_ff;
  lcdcdc_pkg::lcdcdc_pwr_e pwr_ff;
  logic [4:0]  pwr_cnt_ff;

  logic        wen;
  logic        cmd_wr;
  logic        mem_wr;
  logic        mem_rd;
  logic [7:0]  cmd;
  logic        wrap_enable;
  logic        cursor_on;
  logic        hlh;

  // Host writes blocked while reset runs; reads still served
  assign wen    = i_wr && !rst_busy_ff;
  assign cmd_wr = wen && i_addr == `LCDCDC_OFF_CMD;
  assign mem_wr = wen && i_addr == `LCDCDC_OFF_MEMACC && i_wdata[0];
  assign mem_rd = wen && i_addr == `LCDCDC_OFF_MEMACC && !i_wdata[0];
  assign cmd    = i_wdata;
  assign wrap_enable = ram_addr_ctrl_ff[0];
  assign cursor_on   = ram_addr_ctrl_ff[3];
  assign hlh = display_ctrl_bits_ff == `LCDCDC_HLH;

  // =====================================================================
  // System reset timer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rst_busy_ff <= 1'b0;
      rst_cnt_ff  <= '0;
    end
    else if (cmd_wr && second_ff == 2'h0 && cmd == `LCDCDC_CMD_SYSRST)
    begin
      rst_busy_ff <= 1'b1;
      rst_cnt_ff  <= 23'(RESET_CYC - 1);
    end
    else if (rst_busy_ff)
    begin
      if (rst_cnt_ff == '0)
        rst_busy_ff <= 1'b0;
      else
        rst_cnt_ff <= rst_cnt_ff - 23'h1;
    end
  end

  // Host bus strap caught after reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      strap_ff <= 1'b0;
    else if (!strap_ff)
    begin
      strap_ff        <= 1'b1;
      o_host_bus_mode <= i_host_bus_select;
    end
  end

  // =====================================================================
  // Configuration commands
  always_ff @(posedge i_clk)
  begin
    if (i_rst || rst_busy_ff)
    begin
      display_ctrl_bits_ff <= '0;
      all_on_flag_ff       <= 1'b0;
      invert_flag_ff       <= 1'b0;
      lcd_ctrl_bits_ff     <= '0;
      bias_select_ff       <= '0;
      temp_coef_select_ff  <= '0;
      pump_ctrl_bits_ff    <= '0;
      mux_ratio_select_ff  <= 2'h3;
      fixed_row_band_ff    <= '0;
      scroll_offset_ff     <= '0;
      gain_select_ff       <= '0;
      pot_value_ff         <= '0;
      max_col_ff           <= `LCDCDC_RST_MAXCOL;
      second_ff            <= '0;
    end
    else if (cmd_wr && second_ff != 2'h0)
    begin
      // Second byte of a two-byte command
      if (second_ff == 2'h1)
        max_col_ff <= cmd[6:0];
      else if (second_ff == 2'h2)
        {gain_select_ff, pot_value_ff} <= cmd;
      second_ff <= '0;
    end
    else if (cmd_wr)
    begin
      // No-op matches nothing below
      if (cmd[7:2] == 6'h08)
        mux_ratio_select_ff <= cmd[1:0];
      if (cmd[7:2] == 6'h09)
        temp_coef_select_ff <= cmd[1:0];
      if (cmd[7:2] == 6'h0A)
        pump_ctrl_bits_ff[1:0] <= cmd[1:0];
      if (cmd[7:2] == 6'h0B)
        pump_ctrl_bits_ff[3:2] <= cmd[1:0];
      if (cmd == `LCDCDC_CMD_MAXCOL)
        second_ff <= 2'h1;
      if (cmd == `LCDCDC_CMD_GAIN)
        second_ff <= 2'h2;
      if (cmd[7:1] == 7'h18 || cmd[7:2] == 6'h39)
        second_ff <= 2'h3;
      if (cmd[7:4] == 4'h4)
        scroll_offset_ff[3:0] <= cmd[3:0];
      if (cmd[7:4] == 4'h5)
        scroll_offset_ff[6:4] <= cmd[2:0];
      if (cmd[7:4] == 4'h9)
        fixed_row_band_ff <= cmd[3:0];
      if (cmd[7:2] == 6'h28)
        lcd_ctrl_bits_ff[4:3] <= cmd[1:0];
      if (cmd[7:1] == 7'h52)
        all_on_flag_ff <= cmd[0];
      if (cmd[7:1] == 7'h53)
        invert_flag_ff <= cmd[0];
      if (cmd[7:3] == 5'h15)
        display_ctrl_bits_ff <= cmd[2:0];
      if (cmd[7:3] == 5'h18)
        lcd_ctrl_bits_ff[2:0] <= cmd[2:0];
      if (cmd[7:2] == 6'h34)
        lcd_ctrl_bits_ff[6:5] <= cmd[1:0];
      if (cmd[7:2] == 6'h3A)
        bias_select_ff <= cmd[1:0];
    end
  end

  // =====================================================================
  // Address pointers and cursor mode
  always_ff @(posedge i_clk)
  begin
    if (i_rst || rst_busy_ff)
    begin
      column_pointer_ff  <= '0;
      cursor_save_reg_ff <= '0;
      page_pointer_ff    <= '0;
      ram_addr_ctrl_ff   <= {1'b0, `LCDCDC_RST_ADDRC};
    end
    else if (cmd_wr && second_ff == 2'h0)
    begin
      if (cmd[7:4] == 4'h0)
        column_pointer_ff[3:0] <= cmd[3:0];
      if (cmd[7:4] == 4'h1)
        column_pointer_ff[6:4] <= cmd[2:0];
      if (cmd[7:4] == 4'h6)
        page_pointer_ff[3:0] <= cmd[3:0];
      if (cmd[7:4] == 4'h7)
        page_pointer_ff[4] <= cmd[0];
      if (cmd[7:3] == 5'h11)
        ram_addr_ctrl_ff[2:0] <= cmd[2:0];
      if (cmd == `LCDCDC_CMD_CUR_ON)
      begin
        ram_addr_ctrl_ff[3] <= 1'b1;
        cursor_save_reg_ff  <= column_pointer_ff;
      end
      if (cmd == `LCDCDC_CMD_CUR_OFF)
      begin
        ram_addr_ctrl_ff[3] <= 1'b0;
        column_pointer_ff   <= cursor_save_reg_ff;
      end
    end
    else if (mem_wr || (mem_rd && !cursor_on))
    begin
      if (column_pointer_ff >= max_col_ff)
      begin
        // Wrap only outside cursor mode
        if (wrap_enable && !cursor_on)
        begin
          column_pointer_ff <= '0;
          page_pointer_ff <= ram_addr_ctrl_ff[2] ? page_pointer_ff - 5'h1
                                                 : page_pointer_ff + 5'h1;
        end
      end
      else if (hlh && column_pointer_ff == `LCDCDC_MID_FIRST - 7'h01)
        column_pointer_ff <= `LCDCDC_MID_NEXT;
      else
        column_pointer_ff <= column_pointer_ff + 7'h01;
    end
  end

  // =====================================================================
  // Power sequencing
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pwr_ff     <= lcdcdc_pkg::LCDCDC_PWR_SLEEP;
      pwr_cnt_ff <= '0;
    end
    else
    begin
      case (pwr_ff)
        lcdcdc_pkg::LCDCDC_PWR_SLEEP:
          if (display_ctrl_bits_ff != 3'h0)
          begin
            pwr_ff     <= lcdcdc_pkg::LCDCDC_PWR_UP;
            pwr_cnt_ff <= 5'(`LCDCDC_POWER_CYC - 1);
          end
        lcdcdc_pkg::LCDCDC_PWR_UP:
          if (display_ctrl_bits_ff == 3'h0)
            pwr_ff <= lcdcdc_pkg::LCDCDC_PWR_SLEEP;
          else if (pwr_cnt_ff == '0)
            pwr_ff <= lcdcdc_pkg::LCDCDC_PWR_ON;
          else
            pwr_cnt_ff <= pwr_cnt_ff - 5'h1;
        lcdcdc_pkg::LCDCDC_PWR_ON:
          if (display_ctrl_bits_ff == 3'h0)
            pwr_ff <= lcdcdc_pkg::LCDCDC_PWR_SLEEP;
        default:
          pwr_ff <= lcdcdc_pkg::LCDCDC_PWR_SLEEP;
      endcase
    end
  end

  // Driver outputs registered
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_drv                <= '0;
      o_row_hiz            <= 1'b1;
      o_col_gnd            <= 1'b1;
      o_driver_enable_flag <= 1'b0;
    end
    else
    begin
      o_driver_enable_flag <= display_ctrl_bits_ff != 3'h0;
      o_drv.sleep <= pwr_ff == lcdcdc_pkg::LCDCDC_PWR_SLEEP;
      o_drv.rows_active <= pwr_ff == lcdcdc_pkg::LCDCDC_PWR_ON;
      o_drv.col_group_en <= (pwr_ff == lcdcdc_pkg::LCDCDC_PWR_ON)
                          ? display_ctrl_bits_ff : 3'h0;
      o_row_hiz <= pwr_ff != lcdcdc_pkg::LCDCDC_PWR_ON;
      o_col_gnd <= pwr_ff != lcdcdc_pkg::LCDCDC_PWR_ON;
      // Enable overrides all-on/inverse
      o_drv.all_on_eff <= all_on_flag_ff &&
                          pwr_ff == lcdcdc_pkg::LCDCDC_PWR_ON;
      o_drv.invert_eff <= invert_flag_ff &&
                          pwr_ff == lcdcdc_pkg::LCDCDC_PWR_ON;
      o_drv.pump_internal <= pump_ctrl_bits_ff[3:2] == 2'h3;
    end
  end

  // =====================================================================
  // Derived settings decode
  lcdcdc_pkg::lcdcdc_derived_s der;
  always_comb
  begin
    der = '0;
    der.bias_ratio = 4'h9 + {2'h0, bias_select_ff};
    case (mux_ratio_select_ff)
      2'b00:   der.mux_rows = 7'h40;
      2'b01:   der.mux_rows = 7'h50;
      2'b10:   der.mux_rows = 7'h66;
      default: der.mux_rows = 7'h7F;
    endcase
    der.temp_code = {1'b0, temp_coef_select_ff};
    der.shade01_pct = 7'h28 - {4'h0, lcd_ctrl_bits_ff[6:5], 1'b0};
    der.shade10_pct = 7'h3C + {4'h0, lcd_ctrl_bits_ff[6:5], 1'b0};
  end

  // Mux rows as 8 bits (128 does not fit 7)
  logic [7:0] mux_rows8;
  assign mux_rows8 = (mux_ratio_select_ff == 2'b11) ? 8'h80
                                                    : {1'b0, der.mux_rows};

  lcdcdc_line_timer #(
    .CNT_W (12)
  ) u_timer (
    .i_clk           (i_clk),
    .i_rst           (i_rst),
    .i_run           (pwr_ff == lcdcdc_pkg::LCDCDC_PWR_ON),
    .i_lcd_ctrl_bits (lcd_ctrl_bits_ff[4:3]),
    .i_mux_rows      (mux_rows8),
    .o_line_tick     (o_line_tick),
    .o_frame_tick    (o_frame_tick)
  );

  // Pointer and flag outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_column_pointer     <= '0;
      o_page_pointer       <= '0;
      o_reset_pending_flag <= 1'b0;
    end
    else
    begin
      o_column_pointer     <= column_pointer_ff;
      o_page_pointer       <= page_pointer_ff;
      o_reset_pending_flag <= rst_busy_ff;
    end
  end

  // =====================================================================
  // Read port, data one cycle after strobe
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= '0;
    else if (i_rd)
    begin
      case (i_addr)
        `LCDCDC_OFF_STATUS:
          o_rdata <= {24'h0, 1'b0, lcd_ctrl_bits_ff[1],
                      display_ctrl_bits_ff != 3'h0, rst_busy_ff,
                      wrap_enable, gain_select_ff, 1'b1};
        `LCDCDC_OFF_DISP:
          o_rdata <= {24'h0, 1'b0, pwr_ff, display_ctrl_bits_ff,
                      all_on_flag_ff, invert_flag_ff};
        `LCDCDC_OFF_ADDR:
          o_rdata <= {8'h0, cursor_save_reg_ff, ram_addr_ctrl_ff,
                      page_pointer_ff, 1'b0, column_pointer_ff};
        `LCDCDC_OFF_CFG:
          o_rdata <= {1'b0, lcd_ctrl_bits_ff, pot_value_ff, gain_select_ff,
                      pump_ctrl_bits_ff, temp_coef_select_ff,
                      mux_ratio_select_ff, bias_select_ff, max_col_ff[0],
                      1'b0, 4'h0};
        `LCDCDC_OFF_SCROLL:
          o_rdata <= {13'h0, max_col_ff, fixed_row_band_ff, 1'b0,
                      scroll_offset_ff};
        `LCDCDC_OFF_DERIVED:
          o_rdata <= {4'h0, der};
        default:
          o_rdata <= '0;
      endcase
    end
    else
      o_rdata <= '0;
  end
endmodule : lcdcdc_core

// >>> design/lcdcdc_line_timer.sv
`include "lcdcdc_regs.svh"
// Line and frame tick generator
module lcdcdc_line_timer #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Settings
  input  wire logic       i_run,
  input  wire logic [1:0] i_lcd_ctrl_bits,
  input  wire logic [7:0] i_mux_rows,
  // Ticks
  output logic            o_line_tick,
  output logic            o_frame_tick
);
  // =====================================================================
  // Divisors for 13.1, 14.4, 15.8, 17.9 klps at 20 MHz
  logic [CNT_W-1:0] div;
  always_comb
  begin
    case (i_lcd_ctrl_bits)
      2'b00:   div = CNT_W'(1527);
      2'b01:   div = CNT_W'(1389);
      2'b10:   div = CNT_W'(1266);
      default: div = CNT_W'(1117);
    endcase
  end

  logic [CNT_W-1:0] line_cnt_ff;
  logic [7:0]       row_cnt_ff;

  // Line counter
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_run)
    begin
      line_cnt_ff <= '0;
      o_line_tick <= 1'b0;
    end
    else if (line_cnt_ff >= div - CNT_W'(1))
    begin
      line_cnt_ff <= '0;
      o_line_tick <= 1'b1;
    end
    else
    begin
      line_cnt_ff <= line_cnt_ff + CNT_W'(1);
      o_line_tick <= 1'b0;
    end
  end

  // Frame = line rate / mux rows
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !i_run)
    begin
      row_cnt_ff   <= '0;
      o_frame_tick <= 1'b0;
    end
    else if (o_line_tick && row_cnt_ff >= i_mux_rows - 8'h01)
    begin
      row_cnt_ff   <= '0;
      o_frame_tick <= 1'b1;
    end
    else
    begin
      if (o_line_tick)
        row_cnt_ff <= row_cnt_ff + 8'h01;
      o_frame_tick <= 1'b0;
    end
  end
endmodule : lcdcdc_line_timer

// >>> pkg/lcdcdc_pkg.sv
package lcdcdc_pkg;
  // =====================================================================
  // Types
  typedef enum logic [1:0] {
    LCDCDC_PWR_SLEEP = 2'b00,
    LCDCDC_PWR_UP    = 2'b01,
    LCDCDC_PWR_ON    = 2'b10
  } lcdcdc_pwr_e;

  typedef struct packed {
    logic       rows_active;
    logic [2:0] col_group_en;
    logic       sleep;
    logic       all_on_eff;
    logic       invert_eff;
    logic       pump_internal;
  } lcdcdc_drv_s;

  typedef struct packed {
    logic [3:0] bias_ratio;
    logic [6:0] mux_rows;
    logic [2:0] temp_code;
    logic [6:0] shade01_pct;
    logic [6:0] shade10_pct;
  } lcdcdc_derived_s;
endpackage : lcdcdc_pkg

// >>> pkg/lcdcdc_regs.svh
`ifndef LCDCDC_REGS_SVH
`define LCDCDC_REGS_SVH
// =====================================================================
// =====================================================================
// Register offsets (plain port)
`define LCDCDC_OFF_CMD     4'h0
`define LCDCDC_OFF_STATUS  4'h1
`define LCDCDC_OFF_DISP    4'h2
`define LCDCDC_OFF_ADDR    4'h3
`define LCDCDC_OFF_CFG     4'h4
`define LCDCDC_OFF_SCROLL  4'h5
`define LCDCDC_OFF_MEMACC  4'h6
`define LCDCDC_OFF_DERIVED 4'h7
// Command opcodes
`define LCDCDC_CMD_CA_LSB  8'h00
`define LCDCDC_CMD_CA_MSB  8'h10
`define LCDCDC_CMD_MUX     8'h20
`define LCDCDC_CMD_TEMP    8'h24
`define LCDCDC_CMD_LOAD    8'h28
`define LCDCDC_CMD_PUMP    8'h2C
`define LCDCDC_CMD_MAXCOL  8'h32
`define LCDCDC_CMD_SL_LSB  8'h40
`define LCDCDC_CMD_SL_MSB  8'h50
`define LCDCDC_CMD_PA_LSB  8'h60
`define LCDCDC_CMD_PA_MSB  8'h70
`define LCDCDC_CMD_GAIN    8'h81
`define LCDCDC_CMD_ADDRC   8'h88
`define LCDCDC_CMD_FIXED   8'h90
`define LCDCDC_CMD_LRATE   8'hA0
`define LCDCDC_CMD_ALLON   8'hA4
`define LCDCDC_CMD_INV     8'hA6
`define LCDCDC_CMD_DISPEN  8'hA8
`define LCDCDC_CMD_MAP     8'hC0
`define LCDCDC_CMD_GRAY    8'hD0
`define LCDCDC_CMD_SYSRST  8'hE2
`define LCDCDC_CMD_NOP     8'hE3
`define LCDCDC_CMD_BIAS    8'hE8
`define LCDCDC_CMD_CUR_OFF 8'hEE
`define LCDCDC_CMD_CUR_ON  8'hEF
// Reset values and middle-column skip codes
`define LCDCDC_RST_MAXCOL  7'h7F
`define LCDCDC_RST_ADDRC   3'h1
`define LCDCDC_HLH         3'h5
`define LCDCDC_MID_FIRST   7'h30
`define LCDCDC_MID_NEXT    7'h50
// Timing
`define LCDCDC_CLK_HZ      20000000
`define LCDCDC_RESET_US    5000
`define LCDCDC_RESET_CYC   ((`LCDCDC_RESET_US * (`LCDCDC_CLK_HZ / 1000)) / 1000)
`define LCDCDC_POWER_CYC   16
`endif

// >>> verification/lcdcdc_core_props.sv
`include "lcdcdc_regs.svh"
// =====================================================================
// Port checker for the command core
module lcdcdc_core_props #(
  parameter int RESET_CYC = 20
) (
  // Clock and reset
  input wire logic                    i_clk,
  input wire logic                    i_rst,
  // Register port
  input wire logic [3:0]              i_addr,
  input wire logic [7:0]              i_wdata,
  input wire logic                    i_wr,
  // Status and driver controls
  input wire logic [1:0]              o_host_bus_mode,
  input wire logic                    o_reset_pending_flag,
  input wire logic                    o_driver_enable_flag,
  input wire lcdcdc_pkg::lcdcdc_drv_s o_drv,
  input wire logic                    o_row_hiz,
  input wire logic                    o_col_gnd,
  input wire logic [6:0]              o_column_pointer
);
  int   pend_cnt_ff;
  logic cmd_wr;
  logic mem_wr;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Strobe decodes
  assign cmd_wr = i_wr && i_addr == `LCDCDC_OFF_CMD;
  assign mem_wr = i_wr && i_addr == `LCDCDC_OFF_MEMACC;

  // Cycles the reset pending flag has been high
  always_ff @(posedge i_clk)
  begin
    if (i_rst || !o_reset_pending_flag)
      pend_cnt_ff <= 0;
    else
      pend_cnt_ff <= pend_cnt_ff + 1;
  end

  chk_sysrst_starts:
    assert property (cmd_wr && i_wdata == `LCDCDC_CMD_SYSRST &&
      !o_reset_pending_flag |-> ##[1:2] o_reset_pending_flag)
    else $error("system reset did not raise pending flag");
  chk_pend_length:
    assert property ($fell(o_reset_pending_flag) |->
      pend_cnt_ff == RESET_CYC)
    else $error("reset pending length wrong");
  chk_sleep_idle:
    assert property (o_drv.sleep |-> o_row_hiz && o_col_gnd)
    else $error("sleep without idle drivers");
  chk_off_drivers:
    assert property (!o_driver_enable_flag [*3] |->
      !o_drv.rows_active && o_drv.col_group_en == 3'h0)
    else $error("drivers active while disabled");
  chk_de_gates:
    assert property (!o_driver_enable_flag [*3] |->
      !o_drv.all_on_eff && !o_drv.invert_eff)
    else $error("all-on or inverse active while disabled");
  chk_supply_first:
    assert property ($rose(o_driver_enable_flag) |->
      !o_drv.rows_active [*8])
    else $error("rows on before supplies restored");
  chk_power_order:
    assert property ($rose(o_drv.rows_active) |->
      !o_drv.sleep && $past(o_driver_enable_flag, 8))
    else $error("rows on without wake");
  chk_hlh_skip:
    assert property (mem_wr && !$past(i_wr) && !o_reset_pending_flag &&
      o_column_pointer == 7'h2F && o_drv.col_group_en == `LCDCDC_HLH
      |-> ##2 o_column_pointer == `LCDCDC_MID_NEXT)
    else $error("middle column group not skipped");
  chk_nop_quiet:
    assert property (cmd_wr && i_wdata == `LCDCDC_CMD_NOP && !$past(i_wr)
      |-> ##2 o_column_pointer == $past(o_column_pointer, 2))
    else $error("no-op moved the column pointer");
  chk_strap_hold:
    assert property (!$past(i_rst) && !$past(i_rst, 2) && !$past(i_rst, 3)
      |-> $stable(o_host_bus_mode))
    else $error("host bus mode changed after capture");

  // Main scenarios reached
  cov_sysrst: cover property ($rose(o_reset_pending_flag));
  cov_wake:   cover property ($rose(o_drv.rows_active));
  cov_hlh:    cover property (o_drv.col_group_en == `LCDCDC_HLH);
endmodule : lcdcdc_core_props

bind lcdcdc_core lcdcdc_core_props #(.RESET_CYC(RESET_CYC)) u_props (
  .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .o_host_bus_mode,
  .o_reset_pending_flag, .o_driver_enable_flag, .o_drv, .o_row_hiz,
  .o_col_gnd, .o_column_pointer
);

// >>> verification/lcdcdc_host_model.sv
// =====================================================================
// Host processor side of the register port
module lcdcdc_host_model (
  // Clock
  input  wire logic        i_clk,
  // Device answers
  input  wire logic        i_reset_pending_flag,
  input  wire logic [31:0] i_rdata,
  // Requests to the device
  output logic      [3:0]  o_addr,
  output logic      [7:0]  o_wdata,
  output logic             o_wr,
  output logic             o_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet bus at time zero
  initial
  begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One write cycle; address and data scrambled once released
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : wr

  // One read cycle; data taken in the cycle after
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    @(posedge i_clk);
    d = i_rdata;
  endtask : rd

  // Holds off while a device reset is in progress
  task automatic wait_idle(output int n);
    n = 0;
    while (i_reset_pending_flag && n < 1000)
    begin
      @(posedge i_clk);
      n++;
    end
  endtask : wait_idle
endmodule : lcdcdc_host_model

// >>> verification/tb_top.sv
`include "lcdcdc_regs.svh"
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("mismatch %s exp %0h got %0h", nm, e, g); \
    end \
  end
// =====================================================================
// Self-checking bench for the command core
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RST_CYC = 20;
  logic [3:0]              i_addr;
  logic [7:0]              i_wdata;
  logic                    i_clk, i_rst, i_wr, i_rd;
  logic [31:0]             o_rdata, rd_val;
  logic [1:0]              i_host_bus_select, o_host_bus_mode;
  logic                    o_reset_pending_flag, o_driver_enable_flag;
  lcdcdc_pkg::lcdcdc_drv_s o_drv;
  lcdcdc_pkg::lcdcdc_derived_s der;
  logic                    o_row_hiz, o_col_gnd, o_line_tick, o_frame_tick;
  logic [6:0]              o_column_pointer;
  logic [4:0]              o_page_pointer;
  logic [6:0]              mux_tbl [4] = '{7'h40, 7'h50, 7'h66, 7'h7F};
  int                      error_cnt = 0;
  int                      checked = 0;
  int                      n;

  lcdcdc_core #(.RESET_CYC(RST_CYC)) dut (
    .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_host_bus_select, .o_host_bus_mode, .o_reset_pending_flag,
    .o_driver_enable_flag, .o_drv, .o_row_hiz, .o_col_gnd,
    .o_column_pointer, .o_page_pointer, .o_line_tick, .o_frame_tick
  );
  lcdcdc_host_model host (
    .i_clk, .i_reset_pending_flag(o_reset_pending_flag),
    .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd)
  );

  // Clock of 50 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic cmd(input logic [7:0] c);
    host.wr(`LCDCDC_OFF_CMD, c);
  endtask : cmd
  task automatic settle;
    repeat (3) @(posedge i_clk);
  endtask : settle
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask : endt
  task automatic do_reset(input logic [1:0] strap);
    i_host_bus_select <= strap;
    i_rst <= 1'b1;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask : do_reset
  task automatic wait_grp(input logic [2:0] grp);
    for (int k = 0; k < 40 && o_drv.col_group_en !== grp; k++)
      @(posedge i_clk);
    settle();
  endtask : wait_grp
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Cuts a hang short
  initial
  begin
    #(20000 * 50);
    error_cnt++;
    give_verdict();
  end

  // Test sequence
  initial
  begin
    i_rst = 1'b1;
    i_host_bus_select = 2'b00;
    for (int s = 0; s < 4; s++)
    begin
      do_reset(s[1:0]);
      settle();
      `CHK("bus_mode", s[1:0], o_host_bus_mode)
      `CHK("row_hiz", 1'b1, o_row_hiz)
      `CHK("col_gnd", 1'b1, o_col_gnd)
      `CHK("sleep", 1'b1, o_drv.sleep)
    end
    endt("reset");
    for (int i = 0; i < 4; i++)
    begin
      cmd(`LCDCDC_CMD_BIAS | i[7:0]);
      cmd(`LCDCDC_CMD_MUX | i[7:0]);
      cmd(`LCDCDC_CMD_TEMP | i[7:0]);
      cmd(`LCDCDC_CMD_GRAY | i[7:0]);
      host.rd(`LCDCDC_OFF_DERIVED, rd_val);
      der = rd_val[27:0];
      `CHK("bias", 4'h9 + i[3:0], der.bias_ratio)
      `CHK("mux", mux_tbl[i], der.mux_rows)
      `CHK("temp", i[2:0], der.temp_code)
      `CHK("shade01", 7'h28 - 7'(2 * i), der.shade01_pct)
      `CHK("shade10", 7'h3C + 7'(2 * i), der.shade10_pct)
    end
    host.rd(4'hF, rd_val);
    `CHK("unmapped", 32'h0, rd_val)
    cmd(`LCDCDC_CMD_PUMP);
    settle();
    `CHK("pump_ext", 1'b0, o_drv.pump_internal)
    cmd(`LCDCDC_CMD_PUMP | 8'h03);
    settle();
    `CHK("pump_int", 1'b1, o_drv.pump_internal)
    cmd(`LCDCDC_CMD_FIXED | 8'h05);
    cmd(`LCDCDC_CMD_SL_LSB | 8'h03);
    host.rd(`LCDCDC_OFF_SCROLL, rd_val);
    `CHK("fixed_band", 4'h5, rd_val[11:8])
    `CHK("scroll", 7'h03, rd_val[6:0])
    endt("config");
    cmd(`LCDCDC_CMD_ALLON | 8'h01);
    cmd(`LCDCDC_CMD_INV | 8'h01);
    settle();
    `CHK("allon_off", 1'b0, o_drv.all_on_eff)
    `CHK("inv_off", 1'b0, o_drv.invert_eff)
    for (int d = 1; d < 9; d++)
    begin
      cmd(`LCDCDC_CMD_DISPEN | 8'(d % 8 == 0 ? 5 : d));
      wait_grp(3'(d % 8 == 0 ? 5 : d));
      `CHK("groups", 3'(d % 8 == 0 ? 5 : d), o_drv.col_group_en)
      `CHK("de_flag", 1'b1, o_driver_enable_flag)
      `CHK("rows_on", 1'b0, o_row_hiz)
      `CHK("allon_on", 1'b1, o_drv.all_on_eff)
      `CHK("inv_on", 1'b1, o_drv.invert_eff)
    end
    cmd(`LCDCDC_CMD_CA_LSB | 8'h0F);
    cmd(`LCDCDC_CMD_CA_MSB | 8'h02);
    host.wr(`LCDCDC_OFF_MEMACC, 8'h01);
    settle();
    `CHK("hlh_skip", `LCDCDC_MID_NEXT, o_column_pointer)
    cmd(`LCDCDC_CMD_LRATE | 8'h03);
    settle();
    for (n = 0; n < 4000 && !o_line_tick; n++)
      @(posedge i_clk);
    @(posedge i_clk);
    for (n = 1; n < 4000 && !o_line_tick; n++)
      @(posedge i_clk);
    `CHK("line_period", `LCDCDC_CLK_HZ / 17900, n)
    endt("display");
    cmd(`LCDCDC_CMD_CA_LSB | 8'h0A);
    cmd(`LCDCDC_CMD_CA_MSB);
    cmd(`LCDCDC_CMD_CUR_ON);
    host.wr(`LCDCDC_OFF_MEMACC, 8'h00);
    settle();
    `CHK("cur_read", 7'h0A, o_column_pointer)
    host.wr(`LCDCDC_OFF_MEMACC, 8'h01);
    settle();
    `CHK("cur_write", 7'h0B, o_column_pointer)
    cmd(`LCDCDC_CMD_CUR_OFF);
    cmd(`LCDCDC_CMD_NOP);
    settle();
    `CHK("cur_exit", 7'h0A, o_column_pointer)
    host.wr(`LCDCDC_OFF_MEMACC, 8'h00);
    settle();
    `CHK("norm_read", 7'h0B, o_column_pointer)
    cmd(`LCDCDC_CMD_MAXCOL);
    cmd(8'h0C);
    cmd(`LCDCDC_CMD_CA_LSB | 8'h0C);
    cmd(`LCDCDC_CMD_CA_MSB);
    cmd(`LCDCDC_CMD_CUR_ON);
    host.wr(`LCDCDC_OFF_MEMACC, 8'h01);
    settle();
    `CHK("no_wrap", 7'h0C, o_column_pointer)
    cmd(`LCDCDC_CMD_CUR_OFF);
    host.wr(`LCDCDC_OFF_MEMACC, 8'h01);
    settle();
    `CHK("wrap", 7'h00, o_column_pointer)
    `CHK("wrap_page", 5'h01, o_page_pointer)
    endt("cursor");
    cmd(`LCDCDC_CMD_DISPEN);
    wait_grp(3'h0);
    `CHK("de_clear", 1'b0, o_driver_enable_flag)
    `CHK("idle_rows", 1'b1, o_row_hiz)
    `CHK("idle_cols", 1'b1, o_col_gnd)
    `CHK("allon_gate", 1'b0, o_drv.all_on_eff)
    `CHK("tick_idle", 1'b0, o_line_tick | o_frame_tick)
    cmd(`LCDCDC_CMD_SYSRST);
    for (int k = 0; k < 3 && !o_reset_pending_flag; k++)
      @(posedge i_clk);
    `CHK("rst_pend", 1'b1, o_reset_pending_flag)
    cmd(`LCDCDC_CMD_CA_LSB | 8'h05);
    host.wait_idle(n);
    `CHK("rst_len", 1'b1, n >= 12 && n <= RST_CYC)
    settle();
    `CHK("rst_col", 7'h00, o_column_pointer)
    endt("sysreset");
    give_verdict();
  end
endmodule : tb_top
